/* core/dpt_defines.vh */
// register offsets, field positions, reset values and timing counts
`ifndef DPT_DEFINES_VH
`define DPT_DEFINES_VH
`define DPT_OFS_CTRL      8'h00
`define DPT_OFS_STEP_LO   8'h04
`define DPT_OFS_STEP_HI   8'h08
`define DPT_OFS_PHASE_OFS 8'h0C
`define DPT_OFS_ACC_HI    8'h10
`define DPT_OFS_STATUS    8'h14
`define DPT_OFS_IRQ_CLR   8'h18
`define DPT_OFS_IRQ_EN    8'h1C
`define DPT_OFS_FIFO_STAT 8'h20
`define DPT_CTRL_DDS_EN   0
`define DPT_CTRL_HALF     1
`define DPT_CTRL_FIFO_EN  2
`define DPT_CTRL_RST      3'h5
`define DPT_ST_OVF        0
`define DPT_ST_UDF        1
`define DPT_ST_CLIP       2
`define DPT_STEP_MAX      48'h8000_0000_0000
`define DPT_SYN_DIV_LAST  2'h3
`define DPT_RD_DIV_LAST   6'h3F
`define DPT_FIFO_DEPTH    16
`define DPT_FIFO_AW       4
`define DPT_FIFO_FULL     5'h10
`define DPT_FIFO_HALF     5'h08
`define DPT_RESP_OKAY     2'h0
`define DPT_RESP_SLVERR   2'h2
`endif

/* core/dpt_ram.v */
// sample word memory of the clock-crossing fifo, registered read data
module dpt_ram #(
  parameter DEPTH = 16,
  parameter AW    = 4,
  parameter DW    = 32
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire          re,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // storage carries no reset so it can map onto block memory
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data held in a register
  always @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= {DW{1'b0}};
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule // dpt_ram

/* core/dpt_sine.v */
// quarter-wave sine lookup of the synthesis stage, 8-bit offset binary out
module dpt_sine (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        en,
  input  wire [13:0] phase,
  output reg  [7:0]  sample
);
  wire [3:0] idx = phase[12] ? ~phase[11:8] : phase[11:8];
  reg  [6:0] mag;

  // one quadrant of magnitudes; symmetry builds the rest of the cycle
  always @* begin
    case (idx)
      4'h0: mag = 7'd6;
      4'h1: mag = 7'd19;
      4'h2: mag = 7'd31;
      4'h3: mag = 7'd43;
      4'h4: mag = 7'd54;
      4'h5: mag = 7'd65;
      4'h6: mag = 7'd76;
      4'h7: mag = 7'd85;
      4'h8: mag = 7'd94;
      4'h9: mag = 7'd102;
      4'hA: mag = 7'd109;
      4'hB: mag = 7'd115;
      4'hC: mag = 7'd120;
      4'hD: mag = 7'd123;
      4'hE: mag = 7'd126;
      default: mag = 7'd127;
    endcase
  end

  // second half of the cycle is the negative lobe
  always @(posedge aclk) begin
    if (!aresetn) begin
      sample <= 8'h80;
    end else if (en) begin
      sample <= phase[13] ? (8'h80 - {1'b0, mag}) : (8'h80 + {1'b0, mag});
    end
  end
endmodule // dpt_sine

/* core/dpt_top.v */
// phase synthesis stage and digitizer sample clock-crossing fifo with axi4-lite
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`include "dpt_defines.vh"
module dpt_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        dig_clk,
  input  wire [7:0]  dig_data,
  input  wire        smp_rd,
  output wire [31:0] smp_data,
  output reg         smp_valid,
  output reg         smp_not_empty,
  output reg         smp_empty,
  output reg         smp_full,
  output wire [7:0]  dds_sample,
  output reg         dds_clk_out,
  output reg         irq
);
  // software state
  reg  [2:0]  ctrl_reg;
  reg  [31:0] step_lo_reg;
  reg  [15:0] step_hi_reg;
  reg  [13:0] phase_ofs_reg;
  reg  [2:0]  status_reg;
  reg  [2:0]  irq_en_reg;
  // synthesis stage
  reg  [1:0]  syn_div_reg;
  reg         syn_tick_reg;
  reg  [47:0] acc_reg;
  // link sampling and deserializer
  reg         lk_s1_reg;
  reg         lk_s2_reg;
  reg         lk_s3_reg;
  reg  [7:0]  dg_s1_reg;
  reg  [7:0]  dg_s2_reg;
  reg  [31:0] ser_word_reg;
  reg  [1:0]  ser_cnt_reg;
  // fifo
  reg  [4:0]  wptr_reg;
  reg  [4:0]  rptr_reg;
  reg         ne_w_reg;
  reg         ne_s1_reg;
  reg  [5:0]  rd_div_reg;
  reg         rd_tick_reg;
  // axi write holding
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  wire dds_en   = ctrl_reg[`DPT_CTRL_DDS_EN];
  wire half_en  = ctrl_reg[`DPT_CTRL_HALF];
  wire fifo_en  = ctrl_reg[`DPT_CTRL_FIFO_EN];

  // feedback clock divided by four gives the synthesis enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      syn_div_reg  <= 2'h0;
      syn_tick_reg <= 1'b0;
    end else begin
      syn_div_reg  <= syn_div_reg + 2'h1;
      syn_tick_reg <= (syn_div_reg == `DPT_SYN_DIV_LAST);
    end
  end

  // an over-range step is clamped rather than aliasing to a lower frequency
  wire [47:0] step_raw  = {step_hi_reg, step_lo_reg};
  wire        step_over = (step_raw > `DPT_STEP_MAX);
  wire [47:0] step_eff  = step_over ? `DPT_STEP_MAX : step_raw;

  // phase accumulator wraps once per sine cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= 48'h0000_0000_0000;
    end else if (dds_en && syn_tick_reg) begin
      acc_reg <= acc_reg + step_eff;
    end
  end

  // offset shifts output phase only, the accumulator never sees it
  wire [13:0] phase_sum = acc_reg[47:34] + phase_ofs_reg;

  dpt_sine i_dpt_sine (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (syn_tick_reg),
    .phase   (phase_sum),
    .sample  (dds_sample)
  );

  // generated clock is the phase msb, advanced digitally by the offset
  always @(posedge aclk) begin
    if (!aresetn) begin
      dds_clk_out <= 1'b0;
    end else if (syn_tick_reg) begin
      dds_clk_out <= phase_sum[13];
    end
  end

  // link clock and data pass two flops before any logic looks at them
  always @(posedge aclk) begin
    if (!aresetn) begin
      lk_s1_reg <= 1'b0;
      lk_s2_reg <= 1'b0;
      lk_s3_reg <= 1'b0;
      dg_s1_reg <= 8'h00;
      dg_s2_reg <= 8'h00;
    end else begin
      lk_s1_reg <= dig_clk;
      lk_s2_reg <= lk_s1_reg;
      lk_s3_reg <= lk_s2_reg;
      dg_s1_reg <= dig_data;
      dg_s2_reg <= dg_s1_reg;
    end
  end

  wire lk_edge = lk_s2_reg & ~lk_s3_reg;

  // fifo occupancy from the two pointers
  wire [4:0] level      = wptr_reg - rptr_reg;
  wire       fifo_full  = (level == `DPT_FIFO_FULL);
  wire       fifo_empty = (level == 5'h00);

  // write side runs only on digitizer clock edges
  wire wr_try = lk_edge & (ser_cnt_reg == 2'h3) & fifo_en;
  wire wr_ok  = wr_try & ~fifo_full;
  wire ovf_ev = wr_try & fifo_full;

  // deserializer packs four samples, oldest in the low byte
  always @(posedge aclk) begin
    if (!aresetn || !fifo_en) begin
      ser_word_reg <= 32'h0000_0000;
      ser_cnt_reg  <= 2'h0;
    end else if (lk_edge) begin
      ser_word_reg <= {dg_s2_reg, ser_word_reg[31:8]};
      ser_cnt_reg  <= ser_cnt_reg + 2'h1;
    end
  end

  wire [31:0] wr_word = {dg_s2_reg, ser_word_reg[31:8]};

  // local read clock as an enable; its rate only roughly matches the writer
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_div_reg  <= 6'h00;
      rd_tick_reg <= 1'b0;
    end else begin
      rd_div_reg  <= rd_div_reg + 6'h01;
      rd_tick_reg <= (rd_div_reg == `DPT_RD_DIV_LAST);
    end
  end

  wire rd_try = rd_tick_reg & smp_rd;
  wire rd_ok  = rd_try & ~fifo_empty;
  wire udf_ev = rd_try & fifo_empty;

  // pointers move only on accepted transfers
  always @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg <= 5'h00;
      rptr_reg <= 5'h00;
    end else begin
      if (wr_ok) begin
        wptr_reg <= wptr_reg + 5'h01;
      end
      if (rd_ok) begin
        rptr_reg <= rptr_reg + 5'h01;
      end
    end
  end

  dpt_ram #(
    .DEPTH (`DPT_FIFO_DEPTH),
    .AW    (`DPT_FIFO_AW),
    .DW    (32)
  ) i_dpt_ram (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (wr_ok),
    .waddr   (wptr_reg[3:0]),
    .wdata   (wr_word),
    .re      (rd_ok),
    .raddr   (rptr_reg[3:0]),
    .rdata   (smp_data)
  );

  // write-side not-empty; holding it to half full delays a slow-writer underflow
  wire ne_w_next = half_en ? (ne_w_reg ? ~fifo_empty : (level >= `DPT_FIFO_HALF))
                           : ~fifo_empty;

  // not-empty crosses to the reader through two flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      ne_w_reg      <= 1'b0;
      ne_s1_reg     <= 1'b0;
      smp_not_empty <= 1'b0;
      smp_empty     <= 1'b1;
      smp_full      <= 1'b0;
      smp_valid     <= 1'b0;
    end else begin
      ne_w_reg      <= ne_w_next;
      ne_s1_reg     <= ne_w_reg;
      smp_not_empty <= ne_s1_reg;
      smp_empty     <= fifo_empty;
      smp_full      <= fifo_full;
      smp_valid     <= rd_ok;
    end
  end

  // byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [7:0] w_ofs = {aw_addr_reg[7:2], 2'b00};
  wire [7:0] r_ofs = {s_axi_araddr[7:2], 2'b00};
  wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  reg  [31:0] old_sel;
  reg         w_hit;

  // current value of the addressed register for the byte merge
  always @* begin
    old_sel = 32'h0000_0000;
    w_hit   = 1'b1;
    case (w_ofs)
      `DPT_OFS_CTRL:      old_sel = {29'h0, ctrl_reg};
      `DPT_OFS_STEP_LO:   old_sel = step_lo_reg;
      `DPT_OFS_STEP_HI:   old_sel = {16'h0000, step_hi_reg};
      `DPT_OFS_PHASE_OFS: old_sel = {18'h0, phase_ofs_reg};
      `DPT_OFS_IRQ_CLR:   old_sel = 32'h0000_0000;
      `DPT_OFS_IRQ_EN:    old_sel = {29'h0, irq_en_reg};
      default:            w_hit   = 1'b0;
    endcase
  end

  wire [31:0] wr_val = merge(old_sel, w_data_reg, w_strb_reg);
  wire [2:0]  clr    = (do_wr && w_ofs == `DPT_OFS_IRQ_CLR) ? wr_val[2:0] : 3'h0;
  wire [2:0]  ev;

  assign ev[`DPT_ST_OVF]  = ovf_ev;
  assign ev[`DPT_ST_UDF]  = udf_ev;
  assign ev[`DPT_ST_CLIP] = step_over;

  // axi write channel: address and data taken in either order, then one response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DPT_RESP_OKAY;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      ctrl_reg      <= `DPT_CTRL_RST;
      step_lo_reg   <= 32'h0000_0000;
      step_hi_reg   <= 16'h0000;
      phase_ofs_reg <= 14'h0000;
      irq_en_reg    <= 3'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_hit ? `DPT_RESP_OKAY : `DPT_RESP_SLVERR;
        case (w_ofs)
          `DPT_OFS_CTRL:      ctrl_reg      <= wr_val[2:0];
          `DPT_OFS_STEP_LO:   step_lo_reg   <= wr_val;
          `DPT_OFS_STEP_HI:   step_hi_reg   <= wr_val[15:0];
          `DPT_OFS_PHASE_OFS: phase_ofs_reg <= wr_val[13:0];
          `DPT_OFS_IRQ_EN:    irq_en_reg    <= wr_val[2:0];
          default:            ctrl_reg      <= ctrl_reg;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // sticky status: an event in the clearing cycle wins over the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 3'h0;
      irq        <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~clr) | ev;
      irq        <= |(status_reg & irq_en_reg);
    end
  end

  // axi read channel answers one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DPT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `DPT_RESP_OKAY;
      case (r_ofs)
        `DPT_OFS_CTRL:      s_axi_rdata <= {29'h0, ctrl_reg};
        `DPT_OFS_STEP_LO:   s_axi_rdata <= step_lo_reg;
        `DPT_OFS_STEP_HI:   s_axi_rdata <= {16'h0000, step_hi_reg};
        `DPT_OFS_PHASE_OFS: s_axi_rdata <= {18'h0, phase_ofs_reg};
        `DPT_OFS_ACC_HI:    s_axi_rdata <= acc_reg[47:16];
        `DPT_OFS_STATUS:    s_axi_rdata <= {29'h0, status_reg};
        `DPT_OFS_IRQ_CLR:   s_axi_rdata <= 32'h0000_0000;
        `DPT_OFS_IRQ_EN:    s_axi_rdata <= {29'h0, irq_en_reg};
        `DPT_OFS_FIFO_STAT: s_axi_rdata <= {24'h0, level, smp_not_empty,
                                            fifo_full, fifo_empty};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DPT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // dpt_top

/* tb/dpt_top_assertions.sv */
// port-level timing checker for the synthesis stage and sample fifo block
module dpt_chk (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        smp_rd,
  input logic        smp_valid,
  input logic        smp_not_empty,
  input logic        smp_empty,
  input logic        smp_full,
  input logic        dds_clk_out,
  input logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers come at fixed distances from the handshakes
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  // generated clock moves only on the divide-by-four synthesis tick
  a_synth_tick: assert property (
    $changed(dds_clk_out) |=> $stable(dds_clk_out) [*3]) else $error("synthesis tick");
  a_read_on_request: assert property (
    smp_valid |-> $past(smp_rd)) else $error("word without request");
  a_one_word_tick: assert property (
    smp_valid |=> !smp_valid [*8]) else $error("read rate too high");
  a_flags_apart: assert property (
    !(smp_empty && smp_full)) else $error("empty and full together");
  a_sync_delay: assert property (
    $rose(smp_not_empty) |-> $past(!smp_empty)) else $error("not-empty unsynchronised");
  c_full: cover property (smp_full);
  c_word: cover property (smp_valid);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // dpt_chk

bind dpt_top dpt_chk i_dpt_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .smp_rd, .smp_valid, .smp_not_empty, .smp_empty, .smp_full, .dds_clk_out, .irq);

/* tb/dpt_digitizer.sv */
// digitizer model: byte stream whose link clock runs only inside a word frame
module dpt_digitizer (
  output logic       dig_clk,
  output logic [7:0] dig_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    dig_clk = 1'b0;
    dig_data = 8'h00;
  end
  // low byte first; odd start offset keeps link edges off the system clock edges
  task automatic send_word(input logic [31:0] w);
    #3;
    for (int i = 0; i < 4; i++) begin
      dig_data = w[8*i +: 8];
      #40 dig_clk = 1'b1;
      #80 dig_clk = 1'b0;
      #40;
    end
    // stale byte is inverted so it cannot pass for fresh data
    dig_data = ~w[31:24];
  endtask
endmodule // dpt_digitizer

/* tb/dds_phase_tune_and_sample_cdc_test.sv */
// self-checking bench: registers, synthesis stage and sample fifo
`include "dpt_defines.vh"
module dds_phase_tune_and_sample_cdc_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, smp_rd, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, smp_valid, smp_not_empty, smp_empty;
  logic        smp_full, dds_clk_out, irq, dig_clk, ok;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dig_data, dds_sample;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_wdata, s_axi_rdata, smp_data, a0, a1, diff, m;
  logic [15:0] seed;
  logic [31:0] exp_q[$], got_q[$];
  int          fails, samples_checked, n, ready_lag;

  dpt_top i_dpt_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .dig_clk, .dig_data, .smp_rd, .smp_data, .smp_valid, .smp_not_empty,
    .smp_empty, .smp_full, .dds_sample, .dds_clk_out, .irq);
  dpt_digitizer i_dpt_digitizer (.dig_clk, .dig_data);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // every word handed out by the reader, in arrival order
  always @(posedge aclk) begin
    if (smp_valid === 1'b1) got_q.push_back(smp_data);
  end

  function automatic logic [31:0] rand_word();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, seed ^ 16'ha5c3};
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_up(input string what);
    fails++;
    $display("wrong value %s expected done seen timeout", what);
    complete_run();
  endtask
  // bus cycles hold valid until taken; no cycle count is assumed
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (ready_lag == 0);
    // ready may come late; it then stays up so calls in a row never drive it twice
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
      if (i + 1 >= ready_lag) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    if (i == 40) give_up("write answer");
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (ready_lag == 0);
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
      if (i + 1 >= ready_lag) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (i == 40) give_up("read answer");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check_val("write resp", `DPT_RESP_OKAY, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check_val($sformatf("reg %h", a), e, d);
  endtask
  task automatic wait_toggle(output int c);
    logic v;
    v = dds_clk_out;
    for (c = 1; c <= 200; c++) begin
      @(posedge aclk);
      if (dds_clk_out !== v) return;
    end
    give_up("generated clock");
  endtask
  task automatic send(input int k);
    logic [31:0] w;
    repeat (k) begin
      w = rand_word();
      exp_q.push_back(w);
      i_dpt_digitizer.send_word(w);
    end
  endtask
  task automatic wait_words(input int k);
    for (int i = 0; i < 1300; i++) begin
      if (got_q.size() >= k) break;
      @(posedge aclk);
    end
    if (got_q.size() < k) give_up("fifo words");
    while (got_q.size() > 0) check_val("sample word", exp_q.pop_front(), got_q.pop_front());
  endtask
  task automatic wait_ne();
    for (int i = 0; i < 100 && smp_not_empty !== 1'b1; i++) @(posedge aclk);
  endtask

  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    smp_rd = 1'b0;
    aresetn = 1'b0;
    seed = 16'h0051;
    fails = 0;
    samples_checked = 0;
    ready_lag = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`DPT_OFS_CTRL, 32'h0000_0005);
    rd_chk(`DPT_OFS_FIFO_STAT, 32'h0000_0001);
    rd_chk(`DPT_OFS_STATUS, 32'h0000_0000);
    rd_chk(`DPT_OFS_IRQ_CLR, 32'h0000_0000);
    // late ready makes the answer wait, so the hold checks see a stall
    ready_lag = 3;
    axi_read(8'h40, a0, resp);
    check_val("read resp", `DPT_RESP_SLVERR, resp);
    axi_write(8'h40, 32'h0000_0001, resp);
    check_val("write resp", `DPT_RESP_SLVERR, resp);
    ready_lag = 0;
    $display("test registers done");
    m = (rand_word() & 32'h0000_00ff) | 32'h0000_0001;
    wr(`DPT_OFS_STEP_LO, m << 16);
    wr(`DPT_OFS_STEP_HI, 32'h0000_0000);
    axi_read(`DPT_OFS_ACC_HI, a0, resp);
    repeat (40) @(posedge aclk);
    axi_read(`DPT_OFS_ACC_HI, a1, resp);
    diff = a1 - a0;
    ok = (diff % m == 0) && (diff / m >= 10) && (diff / m <= 11);
    check_val("step count", 32'h1, {31'h0, ok});
    wr(`DPT_OFS_STEP_HI, 32'h0000_8001);
    rd_chk(`DPT_OFS_STATUS, 32'h0000_0004);
    wait_toggle(n);
    wait_toggle(n);
    check_val("clamped half period", 32'd4, n);
    wr(`DPT_OFS_STEP_HI, 32'h0000_1000);
    wr(`DPT_OFS_IRQ_CLR, 32'h0000_0004);
    rd_chk(`DPT_OFS_STATUS, 32'h0000_0000);
    wait_toggle(n);
    wait_toggle(n);
    check_val("half period", 32'd32, n);
    wr(`DPT_OFS_PHASE_OFS, 32'h0000_2000);
    wait_toggle(n);
    check_val("offset shift", 32'h1, {31'h0, n < 16});
    wait_toggle(n);
    wait_toggle(n);
    check_val("half period after offset", 32'd32, n);
    check_val("sample sign", {31'h0, ~dds_clk_out}, {31'h0, dds_sample[7]});
    $display("test synthesis done");
    send(3);
    wait_ne();
    check_val("not empty", 32'h1, {31'h0, smp_not_empty});
    check_val("early words", 32'h0, got_q.size());
    smp_rd <= 1'b1;
    wait_words(3);
    repeat (140) @(posedge aclk);
    check_val("empty flag", 32'h1, {31'h0, smp_empty});
    rd_chk(`DPT_OFS_STATUS, 32'h0000_0002);
    smp_rd <= 1'b0;
    $display("test stream done");
    wr(`DPT_OFS_IRQ_CLR, 32'h0000_0007);
    wr(`DPT_OFS_IRQ_EN, 32'h0000_0001);
    send(17);
    check_val("full flag", 32'h1, {31'h0, smp_full});
    rd_chk(`DPT_OFS_FIFO_STAT, 32'h0000_0086);
    rd_chk(`DPT_OFS_STATUS, 32'h0000_0001);
    check_val("irq raised", 32'h1, {31'h0, irq});
    wr(`DPT_OFS_IRQ_EN, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    check_val("irq masked", 32'h0, {31'h0, irq});
    wr(`DPT_OFS_IRQ_CLR, 32'h0000_0001);
    wr(`DPT_OFS_IRQ_EN, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    check_val("irq cleared", 32'h0, {31'h0, irq});
    void'(exp_q.pop_back());
    smp_rd <= 1'b1;
    wait_words(16);
    smp_rd <= 1'b0;
    $display("test full done");
    // with both stages off the phase holds and a word on the link is dropped
    wr(`DPT_OFS_CTRL, 32'h0000_0002);
    axi_read(`DPT_OFS_ACC_HI, a0, resp);
    send(1);
    void'(exp_q.pop_back());
    axi_read(`DPT_OFS_ACC_HI, a1, resp);
    check_val("held phase", a0, a1);
    rd_chk(`DPT_OFS_FIFO_STAT, 32'h0000_0001);
    $display("test disable done");
    wr(`DPT_OFS_CTRL, 32'h0000_0007);
    send(7);
    repeat (20) @(posedge aclk);
    check_val("held not empty", 32'h0, {31'h0, smp_not_empty});
    send(1);
    wait_ne();
    check_val("half not empty", 32'h1, {31'h0, smp_not_empty});
    smp_rd <= 1'b1;
    wait_words(8);
    $display("test half hold done");
    complete_run();
  end
endmodule // dds_phase_tune_and_sample_cdc_test
